// ==== hiap_regs.svh ====
`ifndef HIAP_REGS_SVH
`define HIAP_REGS_SVH

// register offsets, internal address space
`define HIAP_ADDR_EXT_PORT      6'h0F
`define HIAP_ADDR_TEST_CTRL0    6'h32
`define HIAP_ADDR_INDIRECT      6'h37

// indirect address register fields
`define HIAP_IND_VALID_BIT      7
`define HIAP_IND_ADDR_MSB       5

// test control 0 monitor selector field
`define HIAP_SEL_MSB            7
`define HIAP_SEL_LSB            5

// reset values
`define HIAP_EXT_PORT_RST       5'h00
`define HIAP_IND_ADDR_RST       6'h00
`define HIAP_SEL_RST            3'h0

// divided clock output: half period of the toggle, in clk cycles
`define HIAP_CLK_OUT_HALF       8'h02

`endif

// ==== hiap_pkg.sv ====
`default_nettype none
package hiap_pkg;
    // monitor selector patterns
    typedef enum logic [2:0] {
        HIAP_SEL_PORT_A  = 3'h0,
        HIAP_SEL_TST0    = 3'h1,
        HIAP_SEL_TSTTI   = 3'h2,
        HIAP_SEL_TSTB0   = 3'h3,
        HIAP_SEL_TSTB1   = 3'h4,
        HIAP_SEL_PORT_B  = 3'h5,
        HIAP_SEL_PORT_C  = 3'h6,
        HIAP_SEL_TSTC    = 3'h7
    } hiap_sel_t;
endpackage
`default_nettype wire

// ==== hiap_addr_mux.sv ====
`default_nettype none
`include "hiap_regs.svh"
// picks the internal register address from pins or indirect register
module hiap_addr_mux
(
    input  wire logic [5:0] pin_addr,
    input  wire logic [5:0] held_addr,
    input  wire logic       indirect_address_valid,
    output logic      [5:0] int_addr
);
    // held address wins only while valid, bit n maps to line An
    assign int_addr = indirect_address_valid ? held_addr : pin_addr;
endmodule
`default_nettype wire

// ==== hiap_clk_div.sv ====
`default_nettype none
`include "hiap_regs.svh"
// toggles the divided clock output, gated low when asked
module hiap_clk_div
#(
    parameter logic [7:0] HALF = `HIAP_CLK_OUT_HALF
)
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic stop,
    output logic      divided_clock_output
);
    logic [7:0] cnt;

    // a zero half period would wrap the compare to 8'hFF, so it is reported as an error at elaboration
    if (HALF == 8'h00)
    begin : g_bad_half
        $error("hiap_clk_div: HALF must be nonzero");
    end

    // free running toggle unless stopped
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt                  <= 8'h00;
            divided_clock_output <= 1'b0;
        end
        else if (stop)
        begin
            cnt                  <= 8'h00;
            divided_clock_output <= 1'b0;
        end
        else if (cnt == HALF - 8'h01)
        begin
            cnt                  <= 8'h00;
            divided_clock_output <= ~divided_clock_output;
        end
        else
            cnt <= cnt + 8'h01;
    end
endmodule
`default_nettype wire

// ==== hiap_top.sv ====
`default_nettype none
`include "hiap_regs.svh"
module hiap_top
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       dev_select,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [5:0] pin_addr,
    input  wire logic [7:0] data_in,
    input  wire logic [4:0] internal_monitor,
    input  wire logic       clock_out_gate_input,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic      [4:0] monitor_pins,
    output logic            divided_clock_output
);
    logic [5:0]          held_addr;
    logic                indirect_address_valid;
    logic [4:0]          ext_port;
    hiap_pkg::hiap_sel_t mon_sel;
    logic [5:0]          int_addr;
    logic                wr_now;
    logic                wr_prev;
    logic                rd_now;

    hiap_addr_mux u_mux
    (
        .pin_addr               (pin_addr),
        .held_addr              (held_addr),
        .indirect_address_valid (indirect_address_valid),
        .int_addr               (int_addr)
    );

    hiap_clk_div u_div
    (
        .clk                  (clk),
        .nrst                 (nrst),
        .stop                 (clock_out_gate_input),
        .divided_clock_output (divided_clock_output)
    );

    // strobe qualification; write acts once per low pulse
    assign wr_now = dev_select && !write_strobe_n;
    assign rd_now = dev_select && !read_strobe_n;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wr_prev <= 1'b0;
        else
            wr_prev <= wr_now;
    end

    // indirect address register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            indirect_address_valid <= 1'b0;
            held_addr              <= `HIAP_IND_ADDR_RST;
        end
        else if (wr_now && !wr_prev && int_addr == `HIAP_ADDR_INDIRECT)
        begin
            indirect_address_valid <= data_in[`HIAP_IND_VALID_BIT];
            held_addr              <= data_in[`HIAP_IND_ADDR_MSB:0];
        end
    end

    // extended output port register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ext_port <= `HIAP_EXT_PORT_RST;
        else if (wr_now && !wr_prev && int_addr == `HIAP_ADDR_EXT_PORT)
            ext_port <= data_in[4:0];
    end

    // monitor selector in test control 0
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mon_sel <= hiap_pkg::HIAP_SEL_PORT_A;
        else if (wr_now && !wr_prev && int_addr == `HIAP_ADDR_TEST_CTRL0)
            mon_sel <= hiap_pkg::hiap_sel_t'(data_in[`HIAP_SEL_MSB:`HIAP_SEL_LSB]);
    end

    // monitor pin source selection
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            monitor_pins <= 5'h00;
        else
        begin
            unique case (mon_sel)
                hiap_pkg::HIAP_SEL_PORT_A,
                hiap_pkg::HIAP_SEL_PORT_B,
                hiap_pkg::HIAP_SEL_PORT_C: monitor_pins <= ext_port;
                hiap_pkg::HIAP_SEL_TST0,
                hiap_pkg::HIAP_SEL_TSTTI,
                hiap_pkg::HIAP_SEL_TSTB0,
                hiap_pkg::HIAP_SEL_TSTB1,
                hiap_pkg::HIAP_SEL_TSTC:   monitor_pins <= internal_monitor;
            endcase
        end
    end

    // read path; these registers are write only, so they read zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            data_oe  <= 1'b0;
            data_out <= 8'h00;
        end
        else
        begin
            data_oe  <= rd_now;
            data_out <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ==== hiap_asserts.sv ====
`default_nettype none
// port-level checks of the host register bank
module hiap_asserts
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       dev_select,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic [5:0] pin_addr,
    input wire logic [7:0] data_in,
    input wire logic [4:0] internal_monitor,
    input wire logic       clock_out_gate_input,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic [4:0] monitor_pins,
    input wire logic       divided_clock_output
);
    timeunit 1ns;
    timeprecision 1ps;
    // write request seen at the pins
    wire logic wr = dev_select && !write_strobe_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_read_drive_on: assert property (dev_select && !read_strobe_n |=> data_oe)
        else $error("read oe");
    a_idle_drive_off: assert property (!(dev_select && !read_strobe_n) |=> !data_oe)
        else $error("idle oe");
    a_read_data_zero: assert property (data_oe |-> data_out == 8'h00)
        else $error("read data");
    a_gate_holds_low: assert property (clock_out_gate_input [*3] |-> !divided_clock_output)
        else $error("clock gate");
    a_clock_keeps_running: assert property (!clock_out_gate_input [*5]
        |-> divided_clock_output != $past(divided_clock_output, 2)) else $error("clock run");
    a_monitor_stays_put: assert property ((!wr && $stable(internal_monitor)) [*3]
        |-> $stable(monitor_pins)) else $error("monitor moved");
    a_clear_monitor_low: assert property ($rose(nrst) |-> monitor_pins == 5'h00)
        else $error("clear monitor");
    a_clear_outputs_low: assert property ($rose(nrst) |-> !divided_clock_output && !data_oe)
        else $error("clear outputs");
    c_write: cover property (wr ##1 !wr);
    c_read: cover property (data_oe);
    c_gate: cover property (clock_out_gate_input [*3]);
endmodule
bind hiap_top hiap_asserts i_hiap_asserts (.*);
`default_nettype wire

// ==== hiap_host.sv ====
`default_nettype none
// host side of the parallel bus
module hiap_host
(
    input  wire logic       clk,
    output logic            dev_select,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic      [5:0] pin_addr,
    output logic      [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {dev_select, read_strobe_n, write_strobe_n, pin_addr, data_in} = {3'h3, 14'h0};
    // strobe held across one rising edge; released lines show inverted junk
    task automatic access(input logic rd, input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        {dev_select, read_strobe_n, write_strobe_n, pin_addr, data_in} = {1'b1, !rd, rd, a, d};
        @(negedge clk);
        {dev_select, read_strobe_n, write_strobe_n, pin_addr, data_in} = {3'h3, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk = 1'b0;
    logic            nrst = 1'b0;
    logic            loop = 1'b0;
    logic      [4:0] internal_monitor = 5'h0A;
    int              n_fail = 0;
    int              num_checks = 0;
    wire logic       dev_select, read_strobe_n, write_strobe_n, data_oe, divided_clock_output;
    wire logic [5:0] pin_addr;
    wire logic [7:0] data_in, data_out;
    wire logic [4:0] monitor_pins;
    // monitor pin 0 looped back to the clock gate once enabled
    wire logic       clock_out_gate_input = loop && monitor_pins[0];
    always #2 clk = ~clk;
    hiap_host i_hiap_host (.*);
    hiap_top i_hiap_top (.*);
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // write, let the monitor settle, compare it
    task automatic wc(input logic [5:0] a, input logic [7:0] d, input logic [7:0] e);
        i_hiap_host.access(1'b0, a, d);
        repeat (3) @(negedge clk);
        chk("monitor", {3'h0, monitor_pins}, e);
    endtask
    // count high cycles of the clock output over eight cycles
    task automatic edges(input logic [7:0] e);
        logic [7:0] nt;
        nt = 8'h00;
        repeat (2) @(negedge clk);
        repeat (8)
        begin
            @(negedge clk);
            nt += 8'(divided_clock_output === 1'b1);
        end
        chk("clkout", nt, e);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        chk("monitor", {3'h0, monitor_pins}, 8'h00);
        wc(6'h0F, 8'h15, 8'h15);
        i_hiap_host.access(1'b1, 6'h0F, 8'h00);
        chk("read oe", {7'h00, data_oe}, 8'h01);
        chk("read data", data_out, 8'h00);
        for (int s = 0; s < 8; s++)
            wc(6'h32, 8'(s * 32), (s == 0 || s == 5 || s == 6) ? 8'h15 : 8'h0A);
        $display("test 1 end");
        wc(6'h32, 8'h00, 8'h15);
        wc(6'h37, 8'h32, 8'h15);
        wc(6'h0F, 8'h04, 8'h04);
        wc(6'h37, 8'hB7, 8'h04);
        wc(6'h0F, 8'h8F, 8'h04);
        wc(6'h32, 8'hE3, 8'h03);
        $display("test 2 end");
        loop = 1'b1;
        wc(6'h00, 8'h01, 8'h01);
        edges(8'h00);
        wc(6'h00, 8'h00, 8'h00);
        edges(8'h04);
        wc(6'h00, 8'h02, 8'h02);
        nrst = 1'b0;
        @(negedge clk);
        chk("monitor", {3'h0, monitor_pins}, 8'h00);
        nrst = 1'b1;
        wc(6'h32, 8'h20, 8'h0A);
        wc(6'h32, 8'h00, 8'h00);
        wc(6'h0F, 8'h1F, 8'h1F);
        $display("test 3 end");
        complete_run();
    end
endmodule
`default_nettype wire
